// ===== rtl/ipf_pkg.sv
// constants for the interrupt priority field register slice
package ipf_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int PRIO_W = 3;
	localparam int NUM_SRC = 6;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_EXT2_TIMER5 = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CAPTURE3 = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_PWM_EVENT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_FAULT_RTC = 12'h00C;

	// source indices
	localparam int SRC_EXT2 = 0;
	localparam int SRC_T5 = 1;
	localparam int SRC_CAP3 = 2;
	localparam int SRC_PWM = 3;
	localparam int SRC_FLTA = 4;
	localparam int SRC_RTC = 5;

	// field positions
	localparam int LSB_EXT2 = 4;
	localparam int LSB_T5 = 0;
	localparam int LSB_CAP3 = 4;
	localparam int LSB_PWM = 4;
	localparam int LSB_FLTA = 12;
	localparam int LSB_RTC = 8;

	localparam logic [ADDR_W-1:0] SRC_OFF [NUM_SRC] = '{
		OFF_EXT2_TIMER5, OFF_EXT2_TIMER5, OFF_CAPTURE3,
		OFF_PWM_EVENT, OFF_FAULT_RTC, OFF_FAULT_RTC};
	localparam int SRC_LSB [NUM_SRC] = '{
		LSB_EXT2, LSB_T5, LSB_CAP3, LSB_PWM, LSB_FLTA, LSB_RTC};

	// priority codes
	localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
	localparam logic [PRIO_W-1:0] PRIO_LOW = 3'h1;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h7;

	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
endpackage : ipf_pkg

// ===== rtl/ipf_field.sv
// one 3-bit priority field register
`timescale 1ns/1ps
module ipf_field
	import ipf_pkg::*;
#(
	parameter bit IMPL = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [PRIO_W-1:0] wr_data,
	output logic [PRIO_W-1:0] value_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= IMPL ? PRIO_RESET : PRIO_OFF;
		end else if (wr_en && IMPL) begin
			value_q <= wr_data;
		end
	end

	AST_ABSENT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		!IMPL |-> value_q == PRIO_OFF)
		else $error("unimplemented field holds a nonzero value");
endmodule : ipf_field

// ===== rtl/ipf_req_gate.sv
// gates one source request by its priority level
`timescale 1ns/1ps
module ipf_req_gate
	import ipf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_req,
	input wire logic [PRIO_W-1:0] prio,
	output logic req_q,
	output logic [PRIO_W-1:0] level_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= 1'b0;
		end else begin
			req_q <= src_req && (prio != PRIO_OFF);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= PRIO_RESET;
		end else begin
			level_q <= prio;
		end
	end

	AST_DISABLED_QUIET: assert property (@(posedge pclk)
		disable iff (!presetn)
		prio == PRIO_OFF |=> !req_q)
		else $error("disabled source raised a request");

	AST_TOP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		src_req && prio == PRIO_MAX |=> req_q && level_q == PRIO_MAX)
		else $error("level 7 source not presented at level 7");

	AST_LOW_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		src_req && prio == PRIO_LOW |=> req_q && level_q == PRIO_LOW)
		else $error("level 1 source not presented at level 1");
endmodule : ipf_req_gate

// ===== rtl/ipf_priority_regs.sv
// apb register slice holding six interrupt priority fields
`timescale 1ns/1ps

// Overview of operation
// - each 3-bit field is a level; 111 is level 7, highest
// - code 001 is level 1, lowest active; others map binary
// - code 000 disables the source; it never requests
// - bits without a field read zero; writes there do nothing
// - pwm event priority sits in bits 6-4 of its register
// - capture 3 priority sits in bits 6-4 of its register
// - external interrupt 2 priority in bits 6-4; bit 3 unused
// - timer 5 priority in bits 2-0 only on larger variants
module ipf_priority_regs
	import ipf_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter int NSRC = NUM_SRC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NSRC-1:0] src_req,
	output logic [NSRC-1:0] core_req,
	output logic [PRIO_W-1:0] ext_int2_priority,
	output logic [PRIO_W-1:0] timer5_priority,
	output logic [PRIO_W-1:0] capture3_priority,
	output logic [PRIO_W-1:0] pwm_event_priority,
	output logic [PRIO_W-1:0] pwm_fault_a_priority,
	output logic [PRIO_W-1:0] rtc_priority
);
	// lane tables are sized by the package count
	if (NSRC != NUM_SRC) begin : g_bad_nsrc
		$error("NSRC must equal the number of priority fields");
	end

	logic pready_q;
	logic pslverr_q;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic mapped;
	logic setup;
	logic wr_commit;
	logic [NSRC-1:0] fld_wr;
	logic [PRIO_W-1:0] prio [NSRC];
	logic [PRIO_W-1:0] level [NSRC];
	logic [NSRC-1:0] req_q;

	assign setup = psel && !penable;
	assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;

	assign mapped = (paddr == OFF_EXT2_TIMER5) ||
		(paddr == OFF_CAPTURE3) ||
		(paddr == OFF_PWM_EVENT) ||
		(paddr == OFF_FAULT_RTC);

	// one access cycle, answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setup && !mapped;
		end
	end

	always_comb begin
		prdata_d = WORD_ZERO;
		for (int i = 0; i < NSRC; i++) begin
			if (paddr == SRC_OFF[i]) begin
				prdata_d[SRC_LSB[i] +: PRIO_W] = prio[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= WORD_ZERO;
		end else if (setup && !pwrite) begin
			prdata_q <= prdata_d;
		end else begin
			prdata_q <= WORD_ZERO;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_src
			assign fld_wr[g] = wr_commit && (paddr == SRC_OFF[g]);

			ipf_field #(
				.IMPL((g != SRC_T5) || LARGE_VARIANT)
			) u_field (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(fld_wr[g]),
				.wr_data(pwdata[SRC_LSB[g] +: PRIO_W]),
				.value_q(prio[g])
			);

			ipf_req_gate u_gate (
				.pclk(pclk),
				.presetn(presetn),
				.src_req(src_req[g]),
				.prio(prio[g]),
				.req_q(req_q[g]),
				.level_q(level[g])
			);
		end
	endgenerate

	assign core_req = req_q;
	assign ext_int2_priority = level[SRC_EXT2];
	assign timer5_priority = level[SRC_T5];
	assign capture3_priority = level[SRC_CAP3];
	assign pwm_event_priority = level[SRC_PWM];
	assign pwm_fault_a_priority = level[SRC_FLTA];
	assign rtc_priority = level[SRC_RTC];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rd_ext;
	logic rd_cap;
	logic rd_pwm;
	logic rd_flt;
	assign rd_ext = setup && !pwrite && paddr == OFF_EXT2_TIMER5;
	assign rd_cap = setup && !pwrite && paddr == OFF_CAPTURE3;
	assign rd_pwm = setup && !pwrite && paddr == OFF_PWM_EVENT;
	assign rd_flt = setup && !pwrite && paddr == OFF_FAULT_RTC;

	AST_EXT2_LANE: assert property (rd_ext |=>
		prdata[LSB_EXT2 +: PRIO_W] == $past(prio[SRC_EXT2]) &&
		prdata[LSB_T5 +: PRIO_W] == $past(prio[SRC_T5]) &&
		prdata[3] == 1'b0 && prdata[DATA_W-1:7] == '0)
		else $error("shared ext2 and timer5 register read wrong");

	AST_CAP3_LANE: assert property (rd_cap |=>
		prdata[LSB_CAP3 +: PRIO_W] == $past(prio[SRC_CAP3]) &&
		prdata[3:0] == 4'h0 && prdata[DATA_W-1:7] == '0)
		else $error("capture 3 register read wrong");

	AST_PWM_LANE: assert property (rd_pwm |=>
		prdata[LSB_PWM +: PRIO_W] == $past(prio[SRC_PWM]) &&
		prdata[3:0] == 4'h0 && prdata[DATA_W-1:7] == '0)
		else $error("pwm event register read wrong");

	AST_FLT_LANE: assert property (rd_flt |=>
		prdata[LSB_FLTA +: PRIO_W] == $past(prio[SRC_FLTA]) &&
		prdata[LSB_RTC +: PRIO_W] == $past(prio[SRC_RTC]) &&
		prdata[11] == 1'b0 && prdata[7:0] == 8'h00 &&
		prdata[DATA_W-1:15] == '0)
		else $error("fault and clock register read wrong");

	AST_UNUSED_WRITE: assert property (wr_commit &&
		paddr == OFF_PWM_EVENT |=>
		prio[SRC_PWM] == $past(pwdata[LSB_PWM +: PRIO_W]) &&
		prio[SRC_CAP3] == $past(prio[SRC_CAP3]))
		else $error("write did not land only in its field");

	AST_T5_SMALL: assert property (!LARGE_VARIANT |->
		prio[SRC_T5] == PRIO_OFF && !core_req[SRC_T5])
		else $error("timer 5 field active on small variant");

	AST_RESET_LEVEL: assert property ($rose(presetn) |->
		prio[SRC_EXT2] == PRIO_RESET && prio[SRC_RTC] == PRIO_RESET)
		else $error("field not at level 4 after reset");

	AST_ONE_WAIT: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer not exactly one access cycle");

	AST_BAD_ADDR: assert property (setup && !mapped |=>
		pslverr && prdata == WORD_ZERO)
		else $error("unmapped address not refused");
endmodule : ipf_priority_regs

// ===== bench/tb_top.sv
// self-checking bench for the interrupt priority field register slice
`timescale 1ns/1ps
module tb_top
	import ipf_pkg::*;
;
	localparam logic [ADDR_W-1:0] ADDRS [5] = '{OFF_EXT2_TIMER5,
		OFF_CAPTURE3, OFF_PWM_EVENT, OFF_FAULT_RTC, 12'h010};
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_SRC-1:0] src_req;
	logic [NUM_SRC-1:0] core_req;
	logic [PRIO_W-1:0] p_ext2, p_t5, p_cap3, p_pwm, p_flta, p_rtc;
	int miscompares;
	int compares;
	int seed;
	int fld [NUM_SRC];

	ipf_priority_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_req(src_req), .core_req(core_req),
		.ext_int2_priority(p_ext2), .timer5_priority(p_t5),
		.capture3_priority(p_cap3), .pwm_event_priority(p_pwm),
		.pwm_fault_a_priority(p_flta), .rtc_priority(p_rtc));

	always #5 pclk = ~pclk;

	task final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input bit wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			miscompares++;
			final_report();
		end
	endtask : apb

	function automatic logic [31:0] exp_word(input logic [ADDR_W-1:0] a);
		int w = 0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (SRC_OFF[s] === a) w |= fld[s] << SRC_LSB[s];
		end
		return 32'(w);
	endfunction : exp_word

	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		chk({31'h0, er}, {31'h0, a === 12'h010});
		for (int s = 0; s < NUM_SRC; s++) begin
			if (SRC_OFF[s] === a) fld[s] = (d >> SRC_LSB[s]) & 7;
		end
	endtask : wr

	task check_all;
		logic [31:0] rd;
		logic er;
		int r;
		int e;
		foreach (ADDRS[i]) begin
			apb(1'b0, ADDRS[i], 32'h0, rd, er);
			chk(rd, exp_word(ADDRS[i]));
		end
		#1;
		e = 0;
		for (int s = 0; s < NUM_SRC; s++) e |= fld[s] << (3 * s);
		chk({p_rtc, p_flta, p_pwm, p_cap3, p_t5, p_ext2}, 32'(e));
		r = $random(seed);
		@(posedge pclk);
		src_req <= r[5:0];
		repeat (2) @(posedge pclk);
		#1;
		e = 0;
		for (int s = 0; s < NUM_SRC; s++) if (r[s] && fld[s] != 0) e |= 1 << s;
		chk({26'h0, core_req}, 32'(e));
	endtask : check_all

	initial begin
		seed = 17;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		src_req = '0;
		miscompares = 0;
		compares = 0;
		foreach (fld[s]) fld[s] = 4;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		check_all();
		$display("test reset_values done");
		for (int c = 0; c < 8; c++) begin
			foreach (ADDRS[i]) wr(ADDRS[i], 32'(c * 32'h1111_1111) | 32'h8888_8888);
			check_all();
		end
		$display("test all_codes done");
		repeat (30) begin
			wr(ADDRS[{$random(seed)} % 5], $random(seed));
			check_all();
		end
		$display("test random_fields done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (fld[s]) fld[s] = 4;
		check_all();
		$display("test second_reset done");
		final_report();
	end
endmodule : tb_top
